// [rtl/datapath_pkg.sv]
// constants and types shared by the shift, move and indirect datapath
`default_nettype none
package datapath_pkg;
   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PTR_W = 16;
   localparam int OFS_W = 6;
   localparam int MEM_DEPTH = 128;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] ACCUM_RESET = 8'h00;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [15:0] PTR_STEP = 16'h0001;
   localparam logic [7:0] DATA_ZERO = 8'h00;

   // ------------------------------------------------------------------
   // field positions and encodings
   // ------------------------------------------------------------------
   localparam int MSB_POS = 7;
   localparam int LSB_POS = 0;
   localparam logic DEST_ACCUM = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // operation select
   typedef enum logic [1:0] {
      logical_shift_left_op = 2'h0,
      logical_shift_right_op = 2'h1,
      register_move_op = 2'h2,
      indirect_load_accumulator_op = 2'h3
   } op_e;

   // pointer_update_mode encodings
   localparam logic [1:0] MODE_PRE_INC = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_READ = 3'h2,
      ST_EXEC = 3'h4
   } state_e;
endpackage
`default_nettype wire

// [rtl/file_reg_mem.sv]
// file register storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module file_reg_mem
   import datapath_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [6:0] rd_addr_i,
   input wire logic wr_en_i,
   input wire logic [6:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o
);
   logic [7:0] mem_ff [MEM_DEPTH];
   logic [7:0] rd_data_ff;
   logic [7:0] nxt_rd_data;

   // read path, value appears one cycle after the address
   always_comb begin
      nxt_rd_data = mem_ff[rd_addr_i];
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rd_data_ff <= DATA_ZERO;
      end else begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   // write path, storage itself has no reset
   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_ff[wr_addr_i] <= wr_data_i;
      end
   end

   assign rd_data_o = rd_data_ff;
endmodule
`default_nettype wire

// [rtl/shift_move_indirect_datapath.sv]
// shift, register move and indirect load datapath of the 8-bit core
//
// Operation
// - left shift: bit7 to carry, zero in
// - destination bit selects accumulator or file register
// - right shift: bit0 to carry, zero in
// - move copies register, updates only zero flag
// - move to itself keeps contents, tests zero
// - indirect load picks pointer, two-bit update mode
// - relative form adds signed offset, pointer unchanged
// - modes: 00 preinc, 01 predec, 10/11 post
// - indirect reaches the low 7 bits of the pointer address, pointer wraps
`timescale 1ns/1ps
`default_nettype none
module shift_move_indirect_datapath
   import datapath_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   // operation request
   input wire logic op_valid_i,
   input wire logic [1:0] op_code_i,
   input wire logic [6:0] file_addr_i,
   input wire logic dest_sel_i,
   input wire logic ptr_sel_i,
   input wire logic [1:0] upd_mode_i,
   input wire logic rel_form_i,
   input wire logic [5:0] offset_i,
   // preload of file registers while idle
   input wire logic load_en_i,
   input wire logic [6:0] load_addr_i,
   input wire logic [7:0] load_data_i,
   // preload of a pointer while idle
   input wire logic ptr_load_i,
   input wire logic ptr_load_sel_i,
   input wire logic [15:0] ptr_load_val_i,
   // state
   output logic busy_o,
   output logic done_o,
   output logic [7:0] accum_o,
   output logic carry_o,
   output logic zero_o,
   output logic [15:0] ptr0_o,
   output logic [15:0] ptr1_o
);
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   // zero test of an 8-bit result
   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == DATA_ZERO);
   endfunction

   // one step of a pointer, wraps at both ends of its range
   function automatic logic [15:0] ptr_step(input logic [15:0] p,
                                            input logic down);
      if (down) begin
         ptr_step = p - PTR_STEP;
      end else begin
         ptr_step = p + PTR_STEP;
      end
   endfunction

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   state_e state_ff, nxt_state;
   op_e op_ff, nxt_op;
   logic dest_ff, nxt_dest;
   logic [6:0] addr_ff, nxt_addr;
   logic [7:0] accum_ff, nxt_accum;
   logic carry_ff, nxt_carry;
   logic zero_ff, nxt_zero;
   logic [15:0] ptr_ff [2];
   logic [15:0] nxt_ptr [2];
   logic busy_ff, nxt_busy;
   logic done_ff, nxt_done;

   logic [7:0] rd_data;
   logic mem_wr_en;
   logic [6:0] mem_wr_addr;
   logic [7:0] mem_wr_data;

   logic [15:0] sel_ptr;
   logic [15:0] ofs_ext;
   logic [15:0] eff_addr;
   logic step_down;
   logic [7:0] result;
   logic ex_wr_file;

   // ------------------------------------------------------------------
   // operand decode
   // ------------------------------------------------------------------
   // effective address of an indirect load
   always_comb begin
      sel_ptr = ptr_ff[ptr_sel_i];
      ofs_ext = {{(PTR_W - OFS_W){offset_i[OFS_W - 1]}}, offset_i};
      step_down = upd_mode_i[0];
      if (rel_form_i) begin
         eff_addr = sel_ptr + ofs_ext;
      end else if (upd_mode_i == MODE_PRE_INC ||
                   upd_mode_i == MODE_PRE_DEC) begin
         eff_addr = ptr_step(sel_ptr, step_down);
      end else begin
         eff_addr = sel_ptr;
      end
   end

   // result of the executing operation
   always_comb begin
      result = rd_data;
      ex_wr_file = 1'b0;
      unique case (op_ff)
         logical_shift_left_op: begin
            result = {rd_data[MSB_POS - 1:LSB_POS], 1'b0};
            ex_wr_file = (dest_ff == DEST_FILE);
         end
         logical_shift_right_op: begin
            result = {1'b0, rd_data[MSB_POS:LSB_POS + 1]};
            ex_wr_file = (dest_ff == DEST_FILE);
         end
         register_move_op: begin
            result = rd_data;
            ex_wr_file = (dest_ff == DEST_FILE);
         end
         indirect_load_accumulator_op: begin
            result = rd_data;
            ex_wr_file = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // sequencer and architectural state
   // ------------------------------------------------------------------
   // idle takes a request, read waits for the registered data, exec
   // retires it
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_dest = dest_ff;
      nxt_addr = addr_ff;
      nxt_accum = accum_ff;
      nxt_carry = carry_ff;
      nxt_zero = zero_ff;
      nxt_ptr[0] = ptr_ff[0];
      nxt_ptr[1] = ptr_ff[1];
      nxt_busy = busy_ff;
      nxt_done = 1'b0;
      unique case (state_ff)
         ST_IDLE: begin
            if (op_valid_i) begin
               nxt_state = ST_READ;
               nxt_busy = 1'b1;
               nxt_op = op_e'(op_code_i);
               nxt_dest = dest_sel_i;
               if (op_e'(op_code_i) == indirect_load_accumulator_op) begin
                  nxt_addr = eff_addr[FADDR_W - 1:0];
                  if (!rel_form_i) begin
                     nxt_ptr[ptr_sel_i] = ptr_step(sel_ptr,
                                                   step_down);
                  end
               end else begin
                  nxt_addr = file_addr_i;
               end
            end else if (ptr_load_i) begin
               nxt_ptr[ptr_load_sel_i] = ptr_load_val_i;
            end
         end
         ST_READ: begin
            nxt_state = ST_EXEC;
         end
         ST_EXEC: begin
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_zero = is_zero(result);
            if (op_ff == logical_shift_left_op) begin
               nxt_carry = rd_data[MSB_POS];
            end else if (op_ff == logical_shift_right_op) begin
               nxt_carry = rd_data[LSB_POS];
            end
            if (!ex_wr_file) begin
               nxt_accum = result;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         op_ff <= register_move_op;
         dest_ff <= DEST_ACCUM;
         addr_ff <= 7'h00;
         accum_ff <= ACCUM_RESET;
         carry_ff <= 1'b0;
         zero_ff <= 1'b0;
         ptr_ff[0] <= PTR_RESET;
         ptr_ff[1] <= PTR_RESET;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         dest_ff <= nxt_dest;
         addr_ff <= nxt_addr;
         accum_ff <= nxt_accum;
         carry_ff <= nxt_carry;
         zero_ff <= nxt_zero;
         ptr_ff[0] <= nxt_ptr[0];
         ptr_ff[1] <= nxt_ptr[1];
         busy_ff <= nxt_busy;
         done_ff <= nxt_done;
      end
   end

   // ------------------------------------------------------------------
   // file register storage
   // ------------------------------------------------------------------
   // write port shared by the preload path and the write-back
   always_comb begin
      if (state_ff == ST_EXEC) begin
         mem_wr_en = ex_wr_file;
         mem_wr_addr = addr_ff;
         mem_wr_data = result;
      end else begin
         mem_wr_en = load_en_i && (state_ff == ST_IDLE) && !op_valid_i;
         mem_wr_addr = load_addr_i;
         mem_wr_data = load_data_i;
      end
   end

   file_reg_mem u_mem (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .rd_addr_i(addr_ff),
      .wr_en_i(mem_wr_en),
      .wr_addr_i(mem_wr_addr),
      .wr_data_i(mem_wr_data),
      .rd_data_o(rd_data)
   );

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign busy_o = busy_ff;
   assign done_o = done_ff;
   assign accum_o = accum_ff;
   assign carry_o = carry_ff;
   assign zero_o = zero_ff;
   assign ptr0_o = ptr_ff[0];
   assign ptr1_o = ptr_ff[1];
endmodule
`default_nettype wire

// [tb/datapath_properties.sv]
// port-level assertions for the shift, move and indirect datapath
`timescale 1ns/1ps
`default_nettype none
module datapath_properties
   import datapath_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic op_valid_i,
   input wire logic [1:0] op_code_i,
   input wire logic dest_sel_i,
   input wire logic ptr_sel_i,
   input wire logic [1:0] upd_mode_i,
   input wire logic rel_form_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic [7:0] accum_o,
   input wire logic carry_o,
   input wire logic zero_o,
   input wire logic [15:0] ptr0_o,
   input wire logic [15:0] ptr1_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------------
   // request sequences
   // ------------------------------------------------------------------
   sequence accept_s;
      !busy_o && op_valid_i;
   endsequence
   sequence ind_s;
      accept_s ##0 op_code_i == indirect_load_accumulator_op && !rel_form_i;
   endsequence
   sequence run_s;
      busy_o ##1 busy_o ##1 (done_o && !busy_o);
   endsequence
   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   busy_span_a: assert property (accept_s |=> run_s)
      else $error("busy or done timing off");
   done_pulse_a: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   zero_flag_a: assert property (
      done_o && (!$past(dest_sel_i, 3) || $past(op_code_i, 3) == 2'h3)
      |-> zero_o == (accum_o == DATA_ZERO)) else $error("zero flag off");
   move_carry_a: assert property (
      done_o && $past(op_code_i, 3) >= register_move_op |-> $stable(carry_o))
      else $error("carry changed by move or load");
   dest_file_a: assert property (
      done_o && $past(dest_sel_i, 3) && $past(op_code_i, 3) != 2'h3
      |-> $stable(accum_o)) else $error("accumulator changed");
   rel_ptr_a: assert property (
      accept_s ##0 op_code_i == indirect_load_accumulator_op && rel_form_i
      |-> ##3 ptr0_o == $past(ptr0_o, 3) && ptr1_o == $past(ptr1_o, 3))
      else $error("pointer moved in relative form");
   inc_ptr_a: assert property (
      ind_s ##0 !upd_mode_i[0] && !ptr_sel_i |=> ptr1_o == $past(ptr1_o)
      && ptr0_o == 16'($past(ptr0_o) + PTR_STEP)) else $error("bad increment");
   dec_ptr_a: assert property (
      ind_s ##0 upd_mode_i[0] && ptr_sel_i |=> ptr0_o == $past(ptr0_o)
      && ptr1_o == 16'($past(ptr1_o) - PTR_STEP)) else $error("bad decrement");
endmodule
bind shift_move_indirect_datapath datapath_properties u_props (.clock_i,
   .rst_i, .op_valid_i, .op_code_i, .dest_sel_i, .ptr_sel_i, .upd_mode_i,
   .rel_form_i, .busy_o, .done_o, .accum_o, .carry_o, .zero_o, .ptr0_o,
   .ptr1_o);
`default_nettype wire

// [tb/shift_move_indirect_datapath_tb.sv]
// self-checking bench for the shift, move and indirect datapath
`timescale 1ns/1ps
`default_nettype none
module shift_move_indirect_datapath_tb
   import datapath_pkg::*;
;
   logic clock_i, rst_i, op_valid_i, dest_sel_i, ptr_sel_i, rel_form_i;
   logic load_en_i, ptr_load_i, ptr_load_sel_i;
   logic [1:0] op_code_i, upd_mode_i;
   logic [6:0] file_addr_i, load_addr_i;
   logic [5:0] offset_i;
   logic [7:0] load_data_i, accum_o;
   logic [15:0] ptr_load_val_i, ptr0_o, ptr1_o, state_v;
   logic busy_o, done_o, carry_o, zero_o;
   int bad_count = 0;
   int checks_done = 0;
   // accumulator and flags packed for one comparison
   assign state_v = {accum_o, 6'h00, carry_o, zero_o};
   shift_move_indirect_datapath DUT (.clock_i, .rst_i, .op_valid_i,
      .op_code_i, .file_addr_i, .dest_sel_i, .ptr_sel_i, .upd_mode_i,
      .rel_form_i, .offset_i, .load_en_i, .load_addr_i, .load_data_i,
      .ptr_load_i, .ptr_load_sel_i, .ptr_load_val_i, .busy_o, .done_o,
      .accum_o, .carry_o, .zero_o, .ptr0_o, .ptr1_o);
   // ------------------------------------------------------------------
   // clock, shared tasks
   // ------------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // preload one file register while idle
   task automatic load(input logic [6:0] a, input logic [7:0] d);
      @(negedge clock_i);
      load_en_i = 1'b1;
      load_addr_i = a;
      load_data_i = d;
      @(negedge clock_i);
      load_en_i = 1'b0;
   endtask
   // preload one pointer while idle
   task automatic ptr(input logic s, input logic [15:0] v);
      @(negedge clock_i);
      ptr_load_i = 1'b1;
      ptr_load_sel_i = s;
      ptr_load_val_i = v;
      @(negedge clock_i);
      ptr_load_i = 1'b0;
   endtask
   // one operation; returns in the cycle done is high
   task automatic run(input logic [1:0] op, input logic [6:0] f,
         input logic d, input logic [1:0] m, input logic r,
         input logic [5:0] k);
      @(negedge clock_i);
      op_code_i = op;
      file_addr_i = f;
      dest_sel_i = d;
      ptr_sel_i = m[0] ^ f[0]; // low address bit swaps the pointer
      upd_mode_i = m;
      rel_form_i = r;
      offset_i = k;
      op_valid_i = 1'b1;
      @(negedge clock_i);
      op_valid_i = 1'b0;
      for (int i = 0; i < 8 && done_o !== 1'b1; i++) @(negedge clock_i);
      check(16'(done_o), 16'h0001);
   endtask
   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic test_shift();
      logic [7:0] v [4] = '{8'h81, 8'h80, 8'h01, 8'hFE};
      logic [7:0] e;
      for (int i = 0; i < 4; i++) begin
         load(7'h05, v[i]);
         run(logical_shift_left_op, 7'h05, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
         e = {v[i][6:0], 1'b0};
         check(state_v, {e, 6'h00, v[i][7], e == DATA_ZERO});
         run(logical_shift_right_op, 7'h05, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
         e = {1'b0, v[i][7:1]};
         check(state_v, {e, 6'h00, v[i][0], e == DATA_ZERO});
      end
      load(7'h05, 8'h55);
      run(logical_shift_left_op, 7'h05, DEST_FILE, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h7F, 6'h00, 1'b0, 1'b0});
      run(register_move_op, 7'h05, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'hAA, 6'h00, 1'b0, 1'b0});
      load(7'h05, 8'h80);
      run(logical_shift_left_op, 7'h05, DEST_FILE, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'hAA, 6'h00, 1'b1, 1'b1});
      run(register_move_op, 7'h05, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h00, 6'h00, 1'b1, 1'b1});
      $display("test_shift done");
   endtask
   task automatic test_move();
      load(7'h20, 8'h00);
      load(7'h21, 8'h80);
      run(logical_shift_left_op, 7'h21, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
      run(register_move_op, 7'h21, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h80, 6'h00, 1'b1, 1'b0});
      run(register_move_op, 7'h20, DEST_FILE, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h80, 6'h00, 1'b1, 1'b1});
      run(register_move_op, 7'h21, DEST_FILE, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h80, 6'h00, 1'b1, 1'b0});
      run(register_move_op, 7'h20, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h00, 6'h00, 1'b1, 1'b1});
      run(register_move_op, 7'h21, DEST_ACCUM, 2'h0, 1'b0, 6'h00);
      check(state_v, {8'h80, 6'h00, 1'b1, 1'b0});
      $display("test_move done");
   endtask
   task automatic test_indirect();
      logic [7:0] ed [4] = '{8'hC3, 8'h3C, 8'h00, 8'h00};
      logic [15:0] ep [4] = '{16'h0011, 16'h000F, 16'h0011, 16'h000F};
      load(7'h0F, 8'h3C);
      load(7'h10, 8'h00);
      load(7'h11, 8'hC3);
      load(7'h4F, 8'hA5);
      load(7'h7F, 8'h7E);
      for (int m = 0; m < 4; m++) begin
         ptr(m[0], 16'h0010);
         run(indirect_load_accumulator_op, 7'h00, DEST_ACCUM, m[1:0], 1'b0,
            6'h00);
         check(m[0] ? ptr1_o : ptr0_o, ep[m]);
         check(state_v, {ed[m], 6'h00, 1'b1, ed[m] == DATA_ZERO});
      end
      ptr(1'b0, 16'h0030);
      run(indirect_load_accumulator_op, 7'h00, DEST_ACCUM, 2'h0, 1'b1, 6'h20);
      check(state_v, {8'h00, 6'h00, 1'b1, 1'b1});
      run(indirect_load_accumulator_op, 7'h00, DEST_ACCUM, 2'h0, 1'b1, 6'h1F);
      check(state_v, {8'hA5, 6'h00, 1'b1, 1'b0});
      check(ptr0_o, 16'h0030);
      ptr(1'b1, 16'h0000);
      run(indirect_load_accumulator_op, 7'h00, DEST_ACCUM, 2'h1, 1'b0, 6'h00);
      check(ptr1_o, 16'hFFFF);
      check(state_v, {8'h7E, 6'h00, 1'b1, 1'b0});
      ptr(1'b0, 16'hFFFF);
      run(indirect_load_accumulator_op, 7'h00, DEST_ACCUM, 2'h2, 1'b0, 6'h00);
      check(ptr0_o, 16'h0000);
      check(state_v, {8'h7E, 6'h00, 1'b1, 1'b0});
      // second pointer with an increment mode, first pointer untouched
      ptr(1'b1, 16'h0010);
      run(indirect_load_accumulator_op, 7'h01, DEST_ACCUM, 2'h0, 1'b0,
         6'h00);
      check(ptr1_o, 16'h0011);
      check(ptr0_o, 16'h0000);
      check(state_v, {8'hC3, 6'h00, 1'b1, 1'b0});
      $display("test_indirect done");
   endtask
   // ------------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      {op_valid_i, dest_sel_i, ptr_sel_i, rel_form_i, load_en_i} = '0;
      {ptr_load_i, ptr_load_sel_i, op_code_i, upd_mode_i} = '0;
      {file_addr_i, load_addr_i, offset_i, load_data_i} = '0;
      ptr_load_val_i = '0;
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      test_shift();
      test_move();
      test_indirect();
      stop_test();
   end
   initial begin
      #20000;
      bad_count++;
      stop_test();
   end
endmodule
`default_nettype wire
